/* File: mil_pkg.sv */
// constants and types for the microcontroller interrupt logic
package mil_pkg;

   // ==================================================
   // register byte offsets
   localparam logic [4:0] MIL_OFS_CTRL   = 5'h00;
   localparam logic [4:0] MIL_OFS_PEN    = 5'h04;
   localparam logic [4:0] MIL_OFS_PFLAG  = 5'h08;
   localparam logic [4:0] MIL_OFS_OPT    = 5'h0c;
   localparam logic [4:0] MIL_OFS_CMPCFG = 5'h10;
   localparam logic [4:0] MIL_OFS_STAT   = 5'h14;

   // ==================================================
   // irq_control_reg fields
   localparam int MIL_CTRL_GIE  = 7;
   localparam int MIL_CTRL_PEIE = 6;
   localparam int MIL_CTRL_T0IE = 5;
   localparam int MIL_CTRL_XIE  = 4;
   localparam int MIL_CTRL_PCIE = 3;
   localparam int MIL_CTRL_T0IF = 2;
   localparam int MIL_CTRL_XIF  = 1;
   localparam int MIL_CTRL_PCIF = 0;

   // periph_flag_reg / periph_enable_reg fields (same layout)
   localparam int MIL_PER_T1  = 0;
   localparam int MIL_PER_FSM = 2;
   localparam int MIL_PER_C1  = 3;
   localparam int MIL_PER_C2  = 4;
   localparam int MIL_PER_EE  = 7;
   localparam logic [7:0] MIL_PER_MASK = 8'h9d;

   // option, comparator config and status fields
   localparam int MIL_OPT_EDGE = 0;
   localparam int MIL_CMP_DIG  = 0;
   localparam int MIL_STAT_PIN = 0;
   localparam int MIL_STAT_SRV = 1;
   localparam int MIL_STAT_SLP = 2;

   // ==================================================
   // reset values
   localparam logic [7:0] MIL_RST_CTRL = 8'h00;
   localparam logic [7:0] MIL_RST_PEN  = 8'h00;
   localparam logic [7:0] MIL_RST_PFL  = 8'h00;
   localparam logic       MIL_RST_OPT  = 1'b1;
   localparam logic       MIL_RST_CMP  = 1'b0;

   localparam logic [12:0] MIL_VECTOR = 13'h0004;

   // ==================================================
   // types
   typedef enum logic [2:0] {
      MIL_ST_RUN   = 3'b001,
      MIL_ST_SERV  = 3'b010,
      MIL_ST_SLEEP = 3'b100
   } mil_state_t;

   typedef struct packed {
      logic ee_done;
      logic cmp2;
      logic cmp1;
      logic fail_safe;
      logic timer_one_ovf;
   } mil_periph_evt_t;

   typedef struct packed {
      logic [7:0]  ctrl;
      logic [7:0]  pen;
      logic [7:0]  pflag;
      logic        edge_sel;
      logic        pin_digital;
      logic [2:0]  pin_sync;
      logic        pin_stable;
      logic        ext_en_sleep;
      mil_state_t  state;
      logic        take;
      logic        wake;
      logic        dp_wr;
      logic [4:0]  dp_addr;
      logic [31:0] rdata;
   } mil_regs_t;

endpackage : mil_pkg

/* File: mil_irq_logic.sv */
// interrupt collection and dispatch logic with ahb-lite register slave
// Function
// (RULE1) global enable gates every request to core
// (RULE2) each source has its own enable
// (RULE3) reset clears global enable
// (RULE4) return instruction sets global enable again
// (RULE5) control register holds pin, port, timer flags
// (RULE6) peripheral flags: eeprom, comparators, timer, clock
// (RULE7) entry clears global enable, vectors 0004h
// (RULE8) external event entry takes three-four cycles; here pin change to vector take is five clocks
// (RULE9) flags set whatever the enables say
// (RULE10) software clears flags before re-enabling
// (RULE11) clearing global enable suppresses next-cycle entry
// (RULE12) pin edge polarity follows edge select
// (RULE13) valid pin edge sets external flag
// (RULE14) external enable low stops pin requests
// (RULE15) pin interrupt wakes if enabled before sleep
// (RULE16) after wake vector only when globally enabled
// (RULE17) analog pin reads zero, config makes digital
// (RULE18) enabled source wakes regardless of global enable
// (RULE19) request is global enable and flagged source
// (RULE20) pin synchronised, samples compared, one set
`timescale 1ns/10ps
module mil_irq_logic
   import mil_pkg::*;
(
   input  wire logic            i_sys_clk,
   input  wire logic            i_reset,
   // ahb-lite slave
   input  wire logic            i_hsel,
   input  wire logic [31:0]     i_haddr,
   input  wire logic [1:0]      i_htrans,
   input  wire logic            i_hwrite,
   input  wire logic [2:0]      i_hsize,
   input  wire logic [31:0]     i_hwdata,
   input  wire logic            i_hready,
   output logic                 o_hreadyout,
   output logic                 o_hresp,
   output logic [31:0]          o_hrdata,
   // event sources
   input  wire logic            i_ext_irq_pin,
   input  wire logic            i_port_change,
   input  wire logic            i_timer_zero_ovf,
   input  wire mil_periph_evt_t i_periph_evt,
   // processor core
   input  wire logic            i_irq_return_instr,
   input  wire logic            i_sleep_enter,
   output logic                 o_irq_req,
   output logic                 o_vector_take,
   output logic                 o_wake,
   output logic [12:0]          o_vector_addr
);

   // ==================================================
   // state
   mil_regs_t r_q;
   mil_regs_t r_d;

   logic       addr_ok;
   logic       addr_low;
   logic       take_now;
   logic       wr_ctrl;
   logic       wr_pen;
   logic       wr_pfl;
   logic       wr_opt;
   logic       wr_cmp;
   logic       gie_clr_now;
   logic       gie_eff;
   logic       ext_edge;
   logic       pin_level;
   logic [7:0] ctrl_set;
   logic [7:0] pfl_set;
   logic [7:0] ctrl_next;
   logic       any_pending;
   logic       any_wake;
   logic [31:0] rd_mux;

   // ==================================================
   // bus decode
   always_comb
   begin
      addr_ok = i_hsel && i_hready && i_htrans[1] && (i_hsize == 3'h2);
      addr_low = (i_haddr[31:5] == 27'h0);
      wr_ctrl = r_q.dp_wr && (r_q.dp_addr == MIL_OFS_CTRL);
      wr_pen  = r_q.dp_wr && (r_q.dp_addr == MIL_OFS_PEN);
      wr_pfl  = r_q.dp_wr && (r_q.dp_addr == MIL_OFS_PFLAG);
      wr_opt  = r_q.dp_wr && (r_q.dp_addr == MIL_OFS_OPT);
      wr_cmp  = r_q.dp_wr && (r_q.dp_addr == MIL_OFS_CMPCFG);
   end

   // ==================================================
   // pin edge and flag sets
   always_comb
   begin
      // only the agreeing 2nd and 3rd stages are looked at
      ext_edge = (r_q.pin_sync[1] == r_q.pin_sync[2])
                 && (r_q.pin_sync[2] != r_q.pin_stable)
                 && (r_q.pin_sync[2] == r_q.edge_sel)       // see (RULE12) (RULE20)
                 && r_q.pin_digital;                         // see (RULE17)
      pin_level = r_q.pin_stable & r_q.pin_digital;          // see (RULE17)

      ctrl_set = 8'h00;
      ctrl_set[MIL_CTRL_XIF]  = ext_edge;                    // see (RULE13) (RULE9)
      ctrl_set[MIL_CTRL_PCIF] = i_port_change;               // see (RULE5)
      ctrl_set[MIL_CTRL_T0IF] = i_timer_zero_ovf;

      pfl_set = 8'h00;                                       // see (RULE6) (RULE9)
      pfl_set[MIL_PER_T1]  = i_periph_evt.timer_one_ovf;
      pfl_set[MIL_PER_FSM] = i_periph_evt.fail_safe;
      pfl_set[MIL_PER_C1]  = i_periph_evt.cmp1;
      pfl_set[MIL_PER_C2]  = i_periph_evt.cmp2;
      pfl_set[MIL_PER_EE]  = i_periph_evt.ee_done;
   end

   // ==================================================
   // request logic
   always_comb
   begin
      // a write clearing the global enable blocks entry in that same cycle
      gie_clr_now = wr_ctrl && !i_hwdata[MIL_CTRL_GIE];      // see (RULE11)
      gie_eff = r_q.ctrl[MIL_CTRL_GIE] && !gie_clr_now;      // see (RULE1)

      any_pending =
         (r_q.ctrl[MIL_CTRL_XIF]  && r_q.ctrl[MIL_CTRL_XIE]) ||   // see (RULE14)
         (r_q.ctrl[MIL_CTRL_PCIF] && r_q.ctrl[MIL_CTRL_PCIE]) ||  // see (RULE2)
         (r_q.ctrl[MIL_CTRL_T0IF] && r_q.ctrl[MIL_CTRL_T0IE]) ||
         (r_q.ctrl[MIL_CTRL_PEIE] && |(r_q.pflag & r_q.pen));

      // wake ignores the global enable; pin uses enable held at sleep entry
      any_wake =
         (r_q.ctrl[MIL_CTRL_XIF]  && r_q.ext_en_sleep) ||         // see (RULE15)
         (r_q.ctrl[MIL_CTRL_PCIF] && r_q.ctrl[MIL_CTRL_PCIE]) ||  // see (RULE18)
         (r_q.ctrl[MIL_CTRL_T0IF] && r_q.ctrl[MIL_CTRL_T0IE]) ||
         (r_q.ctrl[MIL_CTRL_PEIE] && |(r_q.pflag & r_q.pen));

      // one term feeds both the core request and the dispatch step
      take_now = gie_eff && any_pending;                     // see (RULE19)
   end

   // ==================================================
   // read mux
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      unique case (i_haddr[4:0])
         MIL_OFS_CTRL:   rd_mux[7:0] = r_q.ctrl;
         MIL_OFS_PEN:    rd_mux[7:0] = r_q.pen;
         MIL_OFS_PFLAG:  rd_mux[7:0] = r_q.pflag;
         MIL_OFS_OPT:    rd_mux[MIL_OPT_EDGE] = r_q.edge_sel;
         MIL_OFS_CMPCFG: rd_mux[MIL_CMP_DIG] = r_q.pin_digital;
         MIL_OFS_STAT:
         begin
            rd_mux[MIL_STAT_PIN] = pin_level;
            rd_mux[MIL_STAT_SRV] = (r_q.state == MIL_ST_SERV);
            rd_mux[MIL_STAT_SLP] = (r_q.state == MIL_ST_SLEEP);
         end
         default:        rd_mux = 32'h0000_0000;
      endcase
      // only the low 32 bytes are decoded; anything above reads zero
      if (!addr_low)
      begin
         rd_mux = 32'h0000_0000;
      end
   end

   // ==================================================
   // next state
   always_comb
   begin
      r_d = r_q;
      r_d.take = 1'b0;
      r_d.wake = 1'b0;

      // bus phases, zero wait states
      if (i_hready)
      begin
         // write held for the data phase, where hwdata stands; high addresses ignored
         r_d.dp_wr = addr_ok && i_hwrite && addr_low;
         r_d.dp_addr = i_haddr[4:0];
         // read captured in the address phase: a back-to-back read sees the old value
         if (addr_ok && !i_hwrite)
         begin
            r_d.rdata = rd_mux;
         end
      end

      // pin synchroniser, stable value follows once stages agree
      // first stage read only by the second, so metastability stays in the chain
      r_d.pin_sync = {r_q.pin_sync[1:0], i_ext_irq_pin};
      if (r_q.pin_sync[1] == r_q.pin_sync[2])
      begin
         r_d.pin_stable = r_q.pin_sync[2];                   // see (RULE20)
      end

      // register writes; hardware sets win over software clears
      ctrl_next = r_q.ctrl;
      if (wr_ctrl)
      begin
         ctrl_next = i_hwdata[7:0];
      end
      r_d.ctrl = ctrl_next | ctrl_set;                       // see (RULE9)
      if (wr_pen)
      begin
         r_d.pen = i_hwdata[7:0] & MIL_PER_MASK;
      end
      r_d.pflag = ((wr_pfl ? i_hwdata[7:0] : r_q.pflag) | pfl_set) & MIL_PER_MASK;
      if (wr_opt)
      begin
         r_d.edge_sel = i_hwdata[MIL_OPT_EDGE];
      end
      if (wr_cmp)
      begin
         r_d.pin_digital = i_hwdata[MIL_CMP_DIG];
      end

      // dispatch
      unique case (r_q.state)
         MIL_ST_RUN:
         begin
            // a pending interrupt with the global enable set wins over a sleep request in the same cycle
            if (take_now)                                    // see (RULE19)
            begin
               r_d.take = 1'b1;                              // see (RULE7) (RULE8)
               r_d.ctrl[MIL_CTRL_GIE] = 1'b0;                // see (RULE7)
               r_d.state = MIL_ST_SERV;
            end
            else if (i_sleep_enter)
            begin
               r_d.ext_en_sleep = r_q.ctrl[MIL_CTRL_XIE];    // see (RULE15)
               r_d.state = MIL_ST_SLEEP;
            end
         end
         MIL_ST_SERV:
         begin
            if (i_irq_return_instr)
            begin
               r_d.ctrl[MIL_CTRL_GIE] = 1'b1;                // see (RULE4)
               r_d.state = MIL_ST_RUN;
            end
         end
         MIL_ST_SLEEP:
         begin
            if (any_wake)
            begin
               r_d.wake = 1'b1;
               if (take_now)                                 // see (RULE16)
               begin
                  r_d.take = 1'b1;
                  r_d.ctrl[MIL_CTRL_GIE] = 1'b0;
                  r_d.state = MIL_ST_SERV;
               end
               else
               begin
                  r_d.state = MIL_ST_RUN;
               end
            end
         end
         default:
         begin
            // illegal one-hot code: fall back to run
            r_d.state = MIL_ST_RUN;
         end
      endcase
   end

   // ==================================================
   // registers
   always_ff @(posedge i_sys_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         // every field from a constant; global enable leaves reset cleared
         r_q.ctrl         <= MIL_RST_CTRL;                   // see (RULE3)
         r_q.pen          <= MIL_RST_PEN;
         r_q.pflag        <= MIL_RST_PFL;
         r_q.edge_sel     <= MIL_RST_OPT;
         r_q.pin_digital  <= MIL_RST_CMP;
         r_q.pin_sync     <= 3'h0;
         r_q.pin_stable   <= 1'b0;
         r_q.ext_en_sleep <= 1'b0;
         r_q.state        <= MIL_ST_RUN;
         r_q.take         <= 1'b0;
         r_q.wake         <= 1'b0;
         r_q.dp_wr        <= 1'b0;
         r_q.dp_addr      <= 5'h00;
         r_q.rdata        <= 32'h0000_0000;
      end
      else
      begin
         r_q <= r_d;
      end
   end

   // ==================================================
   // outputs
   // no wait states and no error response: every access ends in one data phase
   assign o_hreadyout   = 1'b1;
   assign o_hresp       = 1'b0;
   assign o_hrdata      = r_q.rdata;
   // combinational so the core sees the request in the cycle the flag stands
   assign o_irq_req     = take_now;                          // see (RULE1) (RULE19)
   assign o_vector_take = r_q.take;
   assign o_wake        = r_q.wake;
   assign o_vector_addr = MIL_VECTOR;

endmodule : mil_irq_logic

/* File: mil_irq_logic_assertions.sv */
// port checker for the interrupt logic
`timescale 1ns/10ps
module mil_irq_logic_assertions
   import mil_pkg::*;
(
   input wire logic        i_sys_clk,
   input wire logic        i_reset,
   input wire logic        o_hreadyout,
   input wire logic        o_hresp,
   input wire logic [31:0] o_hrdata,
   input wire logic        o_irq_req,
   input wire logic        o_vector_take,
   input wire logic        o_wake,
   input wire logic [12:0] o_vector_addr
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);
   // ==================================================
   // entry, wake, vector and bus checks
   sequence s_serviced;
      (!o_vector_take && !o_irq_req) [*2];
   endsequence
   sequence s_wake_gone;
      ##1 !o_wake;
   endsequence
   property p_vec_const;
      o_vector_addr == MIL_VECTOR;
   endproperty
   a_vec_const: assert property (p_vec_const) else $error("vector address wrong");
   property p_take_cause;
      o_vector_take |-> $past(o_irq_req);
   endproperty
   a_take_cause: assert property (p_take_cause) else $error("take without request");
   property p_take_gie;
      o_vector_take |-> !o_irq_req;
   endproperty
   a_take_gie: assert property (p_take_gie) else $error("request kept at entry");
   property p_entry;
      o_vector_take |=> s_serviced;
   endproperty
   a_entry: assert property (p_entry) else $error("entry not masked");
   property p_reset_gie;
      $fell(i_reset) |-> !o_irq_req && !o_vector_take;
   endproperty
   a_reset_gie: assert property (p_reset_gie) else $error("request after reset");
   property p_wake_once;
      o_wake |-> s_wake_gone;
   endproperty
   a_wake_once: assert property (p_wake_once) else $error("wake not a pulse");
   property p_bus_okay;
      o_hreadyout && !o_hresp;
   endproperty
   a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or error");
   property p_rdata_hi;
      o_hrdata[31:8] == 24'h0;
   endproperty
   a_rdata_hi: assert property (p_rdata_hi) else $error("upper read bits set");
   c_entry: cover property (o_irq_req ##1 o_vector_take);
endmodule : mil_irq_logic_assertions

bind mil_irq_logic mil_irq_logic_assertions u_chk (.i_sys_clk, .i_reset, .o_hreadyout, .o_hresp,
   .o_hrdata, .o_irq_req, .o_vector_take, .o_wake, .o_vector_addr);

/* File: mil_core_model.sv */
// core side model: leaves the service routine on request
`timescale 1ns/10ps
module mil_core_model
(
   input  wire logic i_sys_clk,
   input  wire logic i_reset,
   input  wire logic i_take,
   input  wire logic i_serviced,
   output logic      o_ret
);
   logic in_isr_q;
   // return only from inside a routine, after software cleared its flags
   always_ff @(posedge i_sys_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         in_isr_q <= 1'b0;
         o_ret    <= 1'b0;
      end
      else
      begin
         o_ret <= 1'b0;
         if (i_take)
            in_isr_q <= 1'b1;
         else if (in_isr_q && i_serviced)
         begin
            o_ret    <= 1'b1;
            in_isr_q <= 1'b0;
         end
      end
   end
endmodule : mil_core_model

/* File: tb_mil_irq_logic.sv */
// testbench for the interrupt logic
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
   $display("Error %0t: got %h expected %h", $time, (a), (b)); end end
module tb_mil_irq_logic
   import mil_pkg::*;
;
   logic        clk = 0, rst = 1, hsel = 0, hwrite = 0, pin = 0, slp = 0, svc = 0;
   logic [31:0] haddr = 0, hwdata = 0, rdat;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'h2;
   logic [6:0]  evt = 0;
   logic        rdy, resp, req, take, wake, ret;
   logic [31:0] hrdata;
   logic [12:0] vec;
   int          n_errors = 0, comparisons = 0, cyc = 0, takes = 0, wakes = 0, t0, w0, n;
   logic [4:0]  ofs [7] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h14, 5'h18};
   logic [31:0] rv  [7] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0};
   logic [6:0]  sv  [7] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40};
   logic [7:0]  sc  [7] = '{8'h08, 8'h20, 8'h40, 8'h40, 8'h40, 8'h40, 8'h40};
   logic [7:0]  sp  [7] = '{8'h00, 8'h00, 8'h01, 8'h04, 8'h08, 8'h10, 8'h80};
   mil_irq_logic uut (.i_sys_clk(clk), .i_reset(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(rdy), .o_hreadyout(rdy),
      .o_hresp(resp), .o_hrdata(hrdata), .i_ext_irq_pin(pin), .i_port_change(evt[0]),
      .i_timer_zero_ovf(evt[1]), .i_periph_evt(evt[6:2]), .i_irq_return_instr(ret),
      .i_sleep_enter(slp), .o_irq_req(req), .o_vector_take(take), .o_wake(wake), .o_vector_addr(vec));
   mil_core_model u_core (.i_sys_clk(clk), .i_reset(rst), .i_take(take), .i_serviced(svc), .o_ret(ret));
   initial
   begin
      forever #25 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      takes += (take === 1'b1);
      wakes += (wake === 1'b1);
      // whole run is under 500 cycles
      if (cyc == 20000)
      begin
         n_errors++;
         stop_test();
      end
   end
   // ==================================================
   // bus and stimulus tasks
   task ahb(input logic [4:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= {27'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk); while (rdy !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (rdy !== 1'b1);
      rdat = hrdata;
   endtask : ahb
   task rchk(input logic [4:0] a, input logic [31:0] e);
      ahb(a, 1'b0, 32'h0);
      `CHK(rdat, e)
   endtask : rchk
   task ev(input logic [6:0] v);
      @(posedge clk);
      evt <= v;
      @(posedge clk);
      evt <= 7'h0;
      repeat (4) @(posedge clk);
   endtask : ev
   task pn(input logic v);
      @(posedge clk);
      pin <= v;
      repeat (8) @(posedge clk);
   endtask : pn
   task strobe(input int s);
      @(posedge clk);
      if (s) slp <= 1'b1; else svc <= 1'b1;
      @(posedge clk);
      slp <= 1'b0;
      svc <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : strobe
   task stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test
   // ==================================================
   // tests
   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 7; i++) rchk(ofs[i], rv[i]);
      `CHK(vec, MIL_VECTOR)
      $display("test reset values done");
      ev(7'h03);
      rchk(MIL_OFS_CTRL, 32'h05);
      ev(7'h7c);
      rchk(MIL_OFS_PFLAG, 32'h9d);
      `CHK(takes, 0)
      $display("test flags without enables done");
      for (int i = 0; i < 7; i++)
      begin
         ahb(MIL_OFS_PFLAG, 1'b1, 32'h0);
         ahb(MIL_OFS_PEN, 1'b1, {24'h0, sp[i]});
         ahb(MIL_OFS_CTRL, 1'b1, {24'h0, sc[i] | 8'h80});
         t0 = takes;
         ev(~sv[i]);
         `CHK(takes, t0)
         ev(sv[i]);
         `CHK(takes, t0 + 1)
         ahb(MIL_OFS_CTRL, 1'b1, {24'h0, sc[i]});
         ahb(MIL_OFS_PFLAG, 1'b1, 32'h0);
         strobe(0);
         rchk(MIL_OFS_CTRL, {24'h0, sc[i] | 8'h80});
      end
      $display("test per source enables done");
      ahb(MIL_OFS_CTRL, 1'b1, 32'ha0);
      // flag rises in the very data phase that clears the global enable
      fork
         ahb(MIL_OFS_CTRL, 1'b1, 32'h24);
         ev(7'h02);
      join
      rchk(MIL_OFS_CTRL, 32'h24);
      `CHK(takes, t0 + 1)
      ahb(MIL_OFS_CTRL, 1'b1, 32'ha4);
      repeat (3) @(posedge clk);
      `CHK(takes, t0 + 2)
      ahb(MIL_OFS_CTRL, 1'b1, 32'h10);
      strobe(0);
      $display("test pending service done");
      pn(1'b1);
      rchk(MIL_OFS_STAT, 32'h0);
      rchk(MIL_OFS_CTRL, 32'h90);
      pn(1'b0);
      ahb(MIL_OFS_CMPCFG, 1'b1, 32'h1);
      @(posedge clk);
      pin <= 1'b1;
      n = 0;
      do begin @(posedge clk); #1; n++; end while (take !== 1'b1 && n < 20);
      `CHK(n, 5)
      rchk(MIL_OFS_CTRL, 32'h12);
      ahb(MIL_OFS_CTRL, 1'b1, 32'h10);
      strobe(0);
      ahb(MIL_OFS_CTRL, 1'b1, 32'h10);
      pn(1'b0);
      rchk(MIL_OFS_CTRL, 32'h10);
      ahb(MIL_OFS_OPT, 1'b1, 32'h0);
      pn(1'b1);
      rchk(MIL_OFS_CTRL, 32'h10);
      pn(1'b0);
      rchk(MIL_OFS_CTRL, 32'h12);
      ahb(MIL_OFS_CTRL, 1'b1, 32'h10);
      pn(1'b0);
      rchk(MIL_OFS_CTRL, 32'h10);
      $display("test pin edges done");
      ahb(MIL_OFS_OPT, 1'b1, 32'h1);
      t0 = takes;
      w0 = wakes;
      strobe(1);
      rchk(MIL_OFS_STAT, 32'h04);
      pn(1'b1);
      `CHK(wakes, w0 + 1)
      `CHK(takes, t0)
      ahb(MIL_OFS_CTRL, 1'b1, 32'ha0);
      strobe(1);
      ev(7'h02);
      `CHK(wakes, w0 + 2)
      `CHK(takes, t0 + 1)
      ahb(MIL_OFS_CTRL, 1'b1, 32'h20);
      strobe(0);
      $display("test sleep wake done");
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      rchk(MIL_OFS_CTRL, 32'h0);
      rchk(MIL_OFS_PEN, 32'h0);
      $display("test reset in mid run done");
      stop_test();
   end
endmodule : tb_mil_irq_logic
